// [rtl/out_div.v]
`timescale 1ns/1ns
`default_nettype none
module out_div #(
  parameter CW = 5
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // input rate, ratio and run enable
  input  wire          tick_i,
  input  wire [CW-1:0] half_i,
  input  wire          run_i,
  // divided clock and toggle strobe
  output wire          q_o,
  output wire          edge_o
);
  reg [CW-1:0] cnt_r;
  reg          ph_r;
  reg          run_r;
  reg          q_r;
  reg          edge_r;
  wire         wrap = ({1'b0, cnt_r} + {{CW{1'b0}}, 1'b1}) >= {1'b0, half_i};
  wire         ph_nxt = ~ph_r;
  wire         run_nxt = ph_r ? run_i : run_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= {CW{1'b0}};
      ph_r   <= 1'b0;
      run_r  <= 1'b0;
      q_r    <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      edge_r <= 1'b0;
      if (tick_i) begin
        if (wrap) begin
          cnt_r  <= {CW{1'b0}};
          ph_r   <= ph_nxt;
          edge_r <= 1'b1;
          run_r  <= run_nxt;
          q_r    <= ph_nxt & run_nxt;
        end else begin
          cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign q_o    = q_r;
  assign edge_o = edge_r;
endmodule // out_div
`default_nettype wire

// [rtl/pin_sync.v]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter             W    = 1,
  parameter [W-1:0]     INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // raw pins and filtered levels
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] lvl_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] lvl_r;

  // a bit moves only when stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      lvl_r <= INIT;
    end else begin
      s1_r  <= pin_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  assign lvl_o = lvl_r;
endmodule // pin_sync
`default_nettype wire

// [rtl/synth_cfg_map.vh]
`ifndef SYNTH_CFG_MAP_VH
`define SYNTH_CFG_MAP_VH
// register byte offsets inside the window
`define SC_OFS_FBDIV     6'h00
`define SC_OFS_OUTDIV    6'h04
`define SC_OFS_STATUS    6'h08
`define SC_OFS_IRQ_STAT  6'h0c
`define SC_OFS_IRQ_MASK  6'h10
`define SC_OFS_ACTIVE    6'h14
// bus address fields
`define SC_BUS_AW        8
`define SC_WIN_HI        7
`define SC_WIN_LO        6
`define SC_OFS_HI        5
`define SC_OFS_LO        0
// reset values of the serial divider registers
`define SC_RST_FB        10'h1f4
`define SC_RST_NA        3'h2
`define SC_RST_NB        1'h0
`define SC_RST_PRE       1'h1
// pre-divider ratios for each pre-divider pin value
`define SC_PRE_RATIO0    2'h1
`define SC_PRE_RATIO1    2'h2
// first output divider codes
`define SC_NA_DIV2       3'h0
`define SC_NA_DIV4       3'h1
`define SC_NA_DIV6       3'h2
`define SC_NA_DIV8       3'h3
`define SC_NA_DIV12      3'h4
`define SC_NA_DIV16      3'h5
`define SC_NA_DIV32      3'h6
// half periods, in input ticks, per ratio
`define SC_HALF_2        5'h01
`define SC_HALF_4        5'h02
`define SC_HALF_6        5'h03
`define SC_HALF_8        5'h04
`define SC_HALF_12       5'h06
`define SC_HALF_16       5'h08
`define SC_HALF_32       5'h10
// second output: same rate or half rate
`define SC_HALF_B1       5'h01
`define SC_HALF_B2       5'h02
// interrupt event count
`define SC_IRQ_W         3
`endif

// [rtl/synth_divider_config_control.v]
// The address map and register access over Wishbone were decided locally.
`include "synth_cfg_map.vh"
`timescale 1ns/1ns
`default_nettype none
module synth_divider_config_control #(
  parameter XTAL_DIV  = 10,
  parameter LOCK_REFS = 4,
  parameter CRW       = 16
) (
  // clock and reset
  input  wire                   clk_i,
  input  wire                   rst_i,
  // wishbone slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [`SC_BUS_AW-1:0]  wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output wire [31:0]            wb_dat_o,
  output wire                   wb_ack_o,
  // reference pins
  input  wire                   ref_clk_i,
  input  wire                   ref_sel_i,
  input  wire                   bypass_n_i,
  // parallel configuration pins
  input  wire [9:0]             fb_div_i,
  input  wire [2:0]             first_output_divider_i,
  input  wire                   second_output_ratio_i,
  input  wire                   pre_div_i,
  input  wire                   serial_sel_i,
  input  wire [1:0]             adr_sel_i,
  // control pins
  input  wire                   test_en_i,
  input  wire                   first_output_halt_n_i,
  input  wire                   second_output_halt_n_i,
  input  wire                   master_clear_i,
  // outputs
  output wire                   first_output_o,
  output wire                   second_output_o,
  output wire                   lock_o,
  output wire                   irq_o
);
  localparam SW = 25;
  localparam [SW-1:0] SYNC_INIT = {1'b0, 1'b1, `SC_RST_FB, `SC_RST_NA, `SC_RST_NB, `SC_RST_PRE,
                                   1'b0, 2'b00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  // filtered pin levels
  wire       refc_s;
  wire       ref_sel_s;
  wire [9:0] fb_pin_s;
  wire [2:0] na_pin_s;
  wire       nb_pin_s;
  wire       pre_pin_s;
  wire       serial_s;
  wire [1:0] adr_s;
  wire       bypass_n_s;
  wire       test_s;
  wire       halt_a_n_s;
  wire       halt_b_n_s;
  wire       mclr_s;

  pin_sync #(
    .W    (SW),
    .INIT (SYNC_INIT)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({ref_clk_i, ref_sel_i, fb_div_i, first_output_divider_i, second_output_ratio_i, pre_div_i,
             serial_sel_i, adr_sel_i, bypass_n_i, test_en_i, first_output_halt_n_i,
             second_output_halt_n_i, master_clear_i}),
    .lvl_o ({refc_s, ref_sel_s, fb_pin_s, na_pin_s, nb_pin_s, pre_pin_s, serial_s, adr_s,
             bypass_n_s, test_s, halt_a_n_s, halt_b_n_s, mclr_s})
  );

  // serial divider registers
  reg [9:0]           fb_reg_r;
  reg [2:0]           na_reg_r;
  reg                 nb_reg_r;
  reg                 pre_reg_r;
  // active divider settings
  reg [9:0]           fb_r;
  reg [2:0]           na_r;
  reg                 nb_r;
  reg                 pre_r;
  // bus
  reg                 ack_r;
  reg [31:0]          dat_r;
  // interrupts
  reg [`SC_IRQ_W-1:0] irq_stat_r;
  reg [`SC_IRQ_W-1:0] irq_mask_r;
  reg                 irq_r;
  // reference and loop
  reg [15:0]          xt_cnt_r;
  reg                 refc_d_r;
  reg [1:0]           pd_cnt_r;
  reg [CRW-1:0]       credit_r;
  reg [7:0]           lk_cnt_r;
  reg                 lock_r;
  reg                 lock_d_r;

  wire [9:0] fb_nxt  = serial_s ? fb_reg_r  : fb_pin_s;
  wire [2:0] na_nxt  = serial_s ? na_reg_r  : na_pin_s;
  wire       nb_nxt  = serial_s ? nb_reg_r  : nb_pin_s;
  wire       pre_nxt = serial_s ? pre_reg_r : pre_pin_s;
  wire       cfg_chg = {fb_nxt, na_nxt, nb_nxt, pre_nxt} != {fb_r, na_r, nb_r, pre_r};

  always @(posedge clk_i) begin
    if (rst_i) begin
      fb_r  <= `SC_RST_FB;
      na_r  <= `SC_RST_NA;
      nb_r  <= `SC_RST_NB;
      pre_r <= `SC_RST_PRE;
    end else begin
      fb_r  <= fb_nxt;
      na_r  <= na_nxt;
      nb_r  <= nb_nxt;
      pre_r <= pre_nxt;
    end
  end

  // bus decode
  wire              req    = wb_cyc_i & wb_stb_i;
  wire              win    = wb_adr_i[`SC_WIN_HI:`SC_WIN_LO] == adr_s;
  wire [5:0]        ofs    = wb_adr_i[`SC_OFS_HI:`SC_OFS_LO];
  wire              wr     = req & wb_we_i & ack_r & win;
  wire              wr_fb  = wr & (ofs == `SC_OFS_FBDIV);
  wire              wr_od  = wr & (ofs == `SC_OFS_OUTDIV) & wb_sel_i[0];
  wire              wr_ist = wr & (ofs == `SC_OFS_IRQ_STAT) & wb_sel_i[0];
  wire              wr_imk = wr & (ofs == `SC_OFS_IRQ_MASK) & wb_sel_i[0];

  always @(posedge clk_i) begin
    if (rst_i || mclr_s) begin
      fb_reg_r  <= `SC_RST_FB;
      na_reg_r  <= `SC_RST_NA;
      nb_reg_r  <= `SC_RST_NB;
      pre_reg_r <= `SC_RST_PRE;
    end else begin
      if (wr_fb && wb_sel_i[0]) begin
        fb_reg_r[7:0] <= wb_dat_i[7:0];
      end
      if (wr_fb && wb_sel_i[1]) begin
        fb_reg_r[9:8] <= wb_dat_i[9:8];
      end
      if (wr_od) begin
        na_reg_r  <= wb_dat_i[2:0];
        nb_reg_r  <= wb_dat_i[3];
        pre_reg_r <= wb_dat_i[4];
      end
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (!win) begin
      rd_mux = 32'h0000_0000;
    end else if (ofs == `SC_OFS_FBDIV) begin
      rd_mux = {22'h00_0000, fb_reg_r};
    end else if (ofs == `SC_OFS_OUTDIV) begin
      rd_mux = {27'h000_0000, pre_reg_r, nb_reg_r, na_reg_r};
    end else if (ofs == `SC_OFS_STATUS) begin
      rd_mux = {27'h000_0000, test_s, ~bypass_n_s, ref_sel_s, serial_s, lock_r};
    end else if (ofs == `SC_OFS_IRQ_STAT) begin
      rd_mux = {29'h0000_0000, irq_stat_r};
    end else if (ofs == `SC_OFS_IRQ_MASK) begin
      rd_mux = {29'h0000_0000, irq_mask_r};
    end else if (ofs == `SC_OFS_ACTIVE) begin
      rd_mux = {16'h0000, pre_r, nb_r, na_r, 1'b0, fb_r};
    end
  end

  // one wait state, ack for one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end

  wire xt_tick  = xt_cnt_r == (XTAL_DIV - 1);
  wire ext_tick = refc_s & ~refc_d_r;
  wire ref_tick = ref_sel_s ? xt_tick : ext_tick;

  always @(posedge clk_i) begin
    if (rst_i) begin
      xt_cnt_r <= 16'h0000;
      refc_d_r <= 1'b0;
    end else begin
      xt_cnt_r <= xt_tick ? 16'h0000 : xt_cnt_r + 16'h0001;
      refc_d_r <= refc_s;
    end
  end

  wire [1:0] pre_ratio = pre_r ? `SC_PRE_RATIO1 : `SC_PRE_RATIO0;
  wire       pd_wrap   = (pd_cnt_r + 2'h1) >= pre_ratio;
  wire       pfd_tick  = ref_tick & pd_wrap;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pd_cnt_r <= 2'h0;
    end else if (ref_tick) begin
      pd_cnt_r <= pd_wrap ? 2'h0 : pd_cnt_r + 2'h1;
    end
  end

  // loop emits feedback count per compare tick
  wire           vco_pll  = credit_r != {CRW{1'b0}};
  wire [CRW-1:0] credit_d = credit_r - {{(CRW-1){1'b0}}, vco_pll};
  wire           drained  = credit_r <= {{(CRW-1){1'b0}}, 1'b1};
  wire           relock   = cfg_chg | mclr_s;

  always @(posedge clk_i) begin
    if (rst_i || relock) begin
      credit_r <= {CRW{1'b0}};
      lk_cnt_r <= 8'h00;
      lock_r   <= 1'b0;
    end else if (pfd_tick) begin
      credit_r <= credit_d + {{(CRW-10){1'b0}}, fb_r};
      if (!drained) begin
        lk_cnt_r <= 8'h00;
        lock_r   <= 1'b0;
      end else if (lk_cnt_r < LOCK_REFS[7:0]) begin
        lk_cnt_r <= lk_cnt_r + 8'h01;
      end else begin
        lock_r <= 1'b1;
      end
    end else begin
      credit_r <= credit_d;
    end
  end

  wire vco_tick = bypass_n_s ? vco_pll : ref_tick;

  reg [4:0] half_a;
  always @* begin
    case (na_r)
      `SC_NA_DIV2: begin
        half_a = `SC_HALF_2;
      end
      `SC_NA_DIV4: begin
        half_a = `SC_HALF_4;
      end
      `SC_NA_DIV6: begin
        half_a = `SC_HALF_6;
      end
      `SC_NA_DIV8: begin
        half_a = `SC_HALF_8;
      end
      `SC_NA_DIV12: begin
        half_a = `SC_HALF_12;
      end
      `SC_NA_DIV16: begin
        half_a = `SC_HALF_16;
      end
      `SC_NA_DIV32: begin
        half_a = `SC_HALF_32;
      end
      default: begin
        half_a = `SC_HALF_2;
      end
    endcase
  end

  // second output same or half rate
  wire [4:0] half_b = nb_r ? `SC_HALF_B2 : `SC_HALF_B1;
  wire       a_edge;

  out_div #(
    .CW (5)
  ) u_div_a (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (vco_tick),
    .half_i (half_a),
    .run_i  (halt_a_n_s),
    .q_o    (first_output_o),
    .edge_o (a_edge)
  );

  out_div #(
    .CW (5)
  ) u_div_b (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (a_edge),
    .half_i (half_b),
    .run_i  (halt_b_n_s),
    .q_o    (second_output_o),
    .edge_o ()
  );

  // events: lock gained, lock lost, settings changed
  wire [`SC_IRQ_W-1:0] ev = {cfg_chg, lock_d_r & ~lock_r, lock_r & ~lock_d_r};
  wire [`SC_IRQ_W-1:0] clr = wr_ist ? wb_dat_i[`SC_IRQ_W-1:0] : {`SC_IRQ_W{1'b0}};

  // set wins over write-one clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_d_r   <= 1'b0;
      irq_stat_r <= {`SC_IRQ_W{1'b0}};
      irq_mask_r <= {`SC_IRQ_W{1'b0}};
      irq_r      <= 1'b0;
    end else begin
      lock_d_r   <= lock_r;
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      if (wr_imk) begin
        irq_mask_r <= wb_dat_i[`SC_IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign lock_o   = lock_r;
  assign irq_o    = irq_r;
endmodule // synth_divider_config_control
`default_nettype wire

// [sim/board_straps.sv]
`timescale 1ns/1ns
`default_nettype none
module board_straps (
  // clock
  input  wire logic clk_i,
  // board pins
  output wire logic ref_clk_o,
  output wire logic test_en_o
);
  logic [3:0] cnt_r = 4'h0;
  logic       ref_r = 1'b0;
  assign test_en_o = 1'b0;
  assign ref_clk_o = ref_r;
  // reference clock, six cycles high and six low
  always @(posedge clk_i) begin
    if (cnt_r == 4'h5) begin
      cnt_r <= 4'h0;
      ref_r <= ~ref_r;
    end else cnt_r <= cnt_r + 4'h1;
  end
endmodule // board_straps
`default_nettype wire

// [sim/synth_divider_config_control_asserts.sv]
`include "synth_cfg_map.vh"
`timescale 1ns/1ns
`default_nettype none
module cfg_checks (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // bus and pins
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [`SC_BUS_AW-1:0] wb_adr_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [1:0]            adr_sel_i,
  input wire logic                  first_output_halt_n_i,
  input wire logic                  second_output_halt_n_i,
  input wire logic                  master_clear_i,
  // outputs
  input wire logic                  first_output_o,
  input wire logic                  second_output_o,
  input wire logic                  lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] h1_r;
  logic [9:0] h2_r;
  // cycles each halt has been held low
  always @(posedge clk_i) begin
    if (rst_i || first_output_halt_n_i) h1_r <= 10'h000;
    else if (h1_r != 10'h3ff) h1_r <= h1_r + 10'h001;
  end
  always @(posedge clk_i) begin
    if (rst_i || second_output_halt_n_i) h2_r <= 10'h000;
    else if (h2_r != 10'h3ff) h2_r <= h2_r + 10'h001;
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  endsequence
  ack_next_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  win_zero_a: assert property (rd_s and (wb_adr_i[7:6] != adr_sel_i) |=> wb_dat_o == 32'h0000_0000)
    else $error("foreign window read not zero");
  unmap_zero_a: assert property (rd_s and (wb_adr_i[5:0] > 6'h17) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  clear_unlock_a: assert property (master_clear_i [*8] |-> !lock_o)
    else $error("lock held during master clear");
  halt_first_a: assert property (h1_r > 10'h200 |-> !first_output_o)
    else $error("first output runs while halted");
  halt_second_a: assert property (h2_r > 10'h200 |-> !second_output_o)
    else $error("second output runs while halted");
endmodule // cfg_checks
bind synth_divider_config_control cfg_checks i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adr_sel_i(adr_sel_i),
  .first_output_halt_n_i(first_output_halt_n_i), .second_output_halt_n_i(second_output_halt_n_i),
  .master_clear_i(master_clear_i), .first_output_o(first_output_o),
  .second_output_o(second_output_o), .lock_o(lock_o)
);
`default_nettype wire

// [sim/test_synth_divider_config_control.sv]
`timescale 1ns/1ns
`default_nettype none
module test_synth_divider_config_control;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic ack, ref_clk, ref_sel = 1'b1, byp_n = 1'b1, nb = 1'b1, pre = 1'b0, ser = 1'b0, tst;
  logic [9:0] fb = 10'h008;
  logic [2:0] na = 3'h3;
  logic [1:0] asel = 2'h0;
  logic h1_n = 1'b1, h2_n = 1'b1, mc = 1'b0, q1, q2, lock, irq;
  logic [15:0] n;
  logic [15:0] rt [7] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000c, 16'h0010, 16'h0020};
  int failures = 0, samples_checked = 0;
  initial forever #2 clk_i = ~clk_i;
  board_straps i_straps (.clk_i(clk_i), .ref_clk_o(ref_clk), .test_en_o(tst));
  synth_divider_config_control i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_clk_i(ref_clk),
    .ref_sel_i(ref_sel), .bypass_n_i(byp_n), .fb_div_i(fb), .first_output_divider_i(na),
    .second_output_ratio_i(nb), .pre_div_i(pre), .serial_sel_i(ser), .adr_sel_i(asel),
    .test_en_i(tst), .first_output_halt_n_i(h1_n), .second_output_halt_n_i(h2_n),
    .master_clear_i(mc), .first_output_o(q1), .second_output_o(q2), .lock_o(lock), .irq_o(irq));
  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    // only the watchdog ends a wait for ack
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  // clock cycles up to the next rising edge of one output
  task rise(input logic b, output logic [15:0] c);
    logic l;
    c = 16'h0000; l = 1'b1;
    while (!(l === 1'b0 && (b ? q2 : q1) === 1'b1) && c < 16'h07d0) begin
      l = b ? q2 : q1;
      @(posedge clk_i);
      c++;
    end
  endtask
  task per(input logic b, input logic [15:0] e);
    rise(b, n);
    rise(b, n);
    chk({16'h0000, n}, {16'h0000, e});
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk({31'h0, lock}, 32'h0000_0001);
    rd(8'h14, 32'h0000_5808);
    rd(8'h08, 32'h0000_0005);
    bus(1'b1, 8'h0c, 32'h0000_0007);
    bus(1'b1, 8'h00, 32'h0000_0123);
    bus(1'b1, 8'h04, 32'h0000_0005);
    rd(8'h00, 32'h0000_0123);
    rd(8'h04, 32'h0000_0005);
    rd(8'h14, 32'h0000_5808);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_0004);
    ser <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(8'h14, 32'h0000_2923);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    chk(rdat & 32'h0000_0004, 32'h0000_0004);
    bus(1'b1, 8'h0c, 32'h0000_0007);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(8'h08, 32'h0000_0006);
    asel <= 2'h2;
    repeat (10) @(posedge clk_i);
    rd(8'h00, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_00ff);
    rd(8'h80, 32'h0000_0123);
    rd(8'h98, 32'h0000_0000);
    mc <= 1'b1;
    repeat (12) @(posedge clk_i);
    mc <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(8'h80, 32'h0000_01f4);
    rd(8'h84, 32'h0000_0012);
    ser <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk({31'h0, lock}, 32'h0000_0001);
    // loop mode: 8 vco ticks per 10-clk compare tick
    per(1'b0, 16'h000a);
    per(1'b1, 16'h0014);
    pre <= 1'b1;
    repeat (100) @(posedge clk_i);
    per(1'b0, 16'h0014);
    pre <= 1'b0;
    repeat (100) @(posedge clk_i);
    byp_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(8'h88, 32'h0000_000d);
    for (int i = 0; i < 7; i++) begin
      na <= i[2:0];
      repeat (40) @(posedge clk_i);
      per(1'b0, rt[i] * 16'h000a);
      per(1'b1, rt[i] * 16'h0014);
    end
    ref_sel <= 1'b0;
    na <= 3'h0;
    repeat (50) @(posedge clk_i);
    per(1'b0, 16'h0018);
    per(1'b1, 16'h0030);
    h1_n <= 1'b0;
    repeat (600) @(posedge clk_i);
    chk({31'h0, q1}, 32'h0000_0000);
    per(1'b1, 16'h0030);
    h1_n <= 1'b1;
    h2_n <= 1'b0;
    repeat (600) @(posedge clk_i);
    chk({31'h0, q2}, 32'h0000_0000);
    per(1'b0, 16'h0018);
    final_report;
  end
endmodule // test_synth_divider_config_control
`default_nettype wire
